/* shared/alu_pkg.sv */
// Constants, types and decode helper shared by the subtract-from-literal datapath.
package alu_pkg;

  // Datapath and instruction widths.
  localparam int INSTR_W  = 16;
  localparam int DATA_W   = 8;
  localparam int NIBBLE_W = 4;
  localparam int FLAG_W   = 5;

  // Opcode field: the upper byte of the instruction word.
  localparam int              OPC_LSB        = 8;
  localparam int              LIT_LSB        = 0;
  localparam logic [7:0]      OPCODE_SUB_LIT = 8'h08;

  // Bit positions of the arithmetic flags in the status vector.
  localparam int FLAG_CARRY  = 0;
  localparam int FLAG_NIBBLE = 1;
  localparam int FLAG_ZERO   = 2;
  localparam int FLAG_OVF    = 3;
  localparam int FLAG_NEG    = 4;

  // Reset values.
  localparam logic [DATA_W-1:0] ACC_RESET    = 8'h00;
  localparam logic [FLAG_W-1:0] STATUS_RESET = 5'h00;
  localparam logic [DATA_W-1:0] ZERO_BYTE    = 8'h00;

  // Instruction cycle phases: idle, then the three after decode; decode itself happens in the start cycle.
  typedef enum logic [1:0] {
    PH_IDLE,
    PH_READ,
    PH_PROC,
    PH_WRITE
  } phase_t;

  // True when the instruction word is the subtract-accumulator-from-literal operation.
  function automatic logic is_subtract_op(input logic [INSTR_W-1:0] word);
    return word[INSTR_W-1:OPC_LSB] == OPCODE_SUB_LIT;
  endfunction

endpackage

/* shared/alu_if.sv */
// Operand and result bundle between the instruction sequencer and the subtract core.
`timescale 1ns/1ps
interface alu_if #(
  parameter int W = alu_pkg::DATA_W
);
  logic [W-1:0]               lit;
  logic [W-1:0]               acc;
  logic [W-1:0]               res;
  logic [alu_pkg::FLAG_W-1:0] flags;

  modport drv  (output lit, output acc, input  res, input  flags);
  modport core (input  lit, input  acc, output res, output flags);
endinterface

/* hw/sub_lit_core.sv */
// Combinational core that forms literal minus accumulator and its five flags.
`timescale 1ns/1ps
module sub_lit_core #(
  parameter int W = alu_pkg::DATA_W
) (
  // Operands in, result and flags out.
  alu_if.core bus
);
  import alu_pkg::*;

  // The nibble carry needs at least one bit above the low nibble.
  if (W <= NIBBLE_W) begin : g_bad_width
    $error("sub_lit_core: width must exceed the nibble width");
  end

  logic [W:0]          diff;
  logic [NIBBLE_W:0]   nib;
  logic [W-1:0]        res;
  logic [FLAG_W-1:0]   flags;

  // Subtraction is done as literal plus inverted accumulator plus one, so the carry out
  // reads directly as "no borrow", which is how the carry and nibble carry flags behave.
  always_comb begin
    diff  = {1'b0, bus.lit} + {1'b0, ~bus.acc} + {{W{1'b0}}, 1'b1}; // see RL1
    nib   = {1'b0, bus.lit[NIBBLE_W-1:0]} + {1'b0, ~bus.acc[NIBBLE_W-1:0]}
            + {{NIBBLE_W{1'b0}}, 1'b1};
    res   = diff[W-1:0];
    flags = STATUS_RESET;
    flags[FLAG_CARRY]  = diff[W];                                   // see RL5, RL7
    flags[FLAG_NIBBLE] = nib[NIBBLE_W];                             // see RL8
    flags[FLAG_ZERO]   = (res == {W{1'b0}});                        // see RL6
    flags[FLAG_OVF]    = (bus.lit[W-1] != bus.acc[W-1])
                         && (res[W-1] != bus.lit[W-1]);             // see RL8
    flags[FLAG_NEG]    = res[W-1];                                  // see RL8
  end

  assign bus.res   = res;
  assign bus.flags = flags;

endmodule

/* hw/subtract_w_from_literal_alu.sv */
// Accumulator datapath slice executing the subtract-accumulator-from-literal instruction.
//
// What this block does
// (RL1) The 8-bit literal minus the accumulator is written back into the accumulator.
// (RL2) The operation updates the negative, overflow, carry, nibble carry and zero flags only.
// (RL3) A word whose upper byte is 08h is decoded as this operation, its low byte the literal.
// (RL4) One word, one instruction cycle: decode, read literal, process, write accumulator.
// (RL5) An accumulator above the literal gives the wrapped result, carry clear and zero clear.
// (RL6) An accumulator equal to the literal gives zero, zero set, carry set and negative clear.
// (RL7) A literal above the accumulator gives the positive difference, carry set and zero clear.
// (RL8) Nibble carry is no borrow from the low nibble, overflow is signed, negative is bit 7.
`timescale 1ns/1ps
module subtract_w_from_literal_alu (
  // Clock and reset.
  input  wire logic                          i_clk,
  input  wire logic                          i_rst_n,
  // Instruction issue from the pipeline.
  input  wire logic                          i_cycle_start,
  input  wire logic [alu_pkg::INSTR_W-1:0]   i_instr,
  // Accumulator and status writes from neighbouring instructions.
  input  wire logic                          i_acc_wr_en,
  input  wire logic [alu_pkg::DATA_W-1:0]    i_acc_wr_data,
  input  wire logic                          i_status_wr_en,
  input  wire logic [alu_pkg::FLAG_W-1:0]    i_status_wr_data,
  // Architectural state and progress.
  output logic [alu_pkg::DATA_W-1:0]         o_acc,
  output logic [alu_pkg::FLAG_W-1:0]         o_status,
  output logic                               o_busy,
  output logic                               o_write_strobe
);
  import alu_pkg::*;

  phase_t                phase_reg;
  phase_t                phase_next;
  logic                  hit_reg;
  logic [INSTR_W-1:0]    instr_reg;
  logic [DATA_W-1:0]     literal_reg;
  logic [DATA_W-1:0]     result_reg;
  logic [FLAG_W-1:0]     flags_reg;
  logic [DATA_W-1:0]     acc_reg;
  logic [FLAG_W-1:0]     status_reg;
  logic                  start_ok;
  logic                  decode_hit;
  logic                  write_strobe;

  alu_if #(.W(DATA_W)) core_bus ();

  sub_lit_core #(
    .W   (DATA_W)
  ) u_core (
    .bus (core_bus)
  );

  // A start is honoured only between instructions; one arriving mid-cycle is dropped.
  assign start_ok     = i_cycle_start && (phase_reg == PH_IDLE);
  assign decode_hit   = is_subtract_op(i_instr);                   // see RL3
  assign write_strobe = (phase_reg == PH_WRITE) && hit_reg;

  // Phase sequencer: the start cycle decodes, then read, process and write follow.
  always_comb begin
    case (phase_reg)
      PH_IDLE:  phase_next = start_ok ? PH_READ : PH_IDLE;          // see RL4
      PH_READ:  phase_next = PH_PROC;
      PH_PROC:  phase_next = PH_WRITE;
      PH_WRITE: phase_next = PH_IDLE;
      default:  phase_next = PH_IDLE;
    endcase
  end

  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      phase_reg <= PH_IDLE;
    end else begin
      phase_reg <= phase_next;
    end
  end

  // Decode: latch the instruction word and whether it is ours.
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      hit_reg   <= 1'b0;
      instr_reg <= {INSTR_W{1'b0}};
    end else if (start_ok) begin
      hit_reg   <= decode_hit;                                      // see RL3
      instr_reg <= i_instr;
    end
  end

  // Read: the literal is the low byte of the latched word.
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      literal_reg <= ZERO_BYTE;
    end else if (phase_reg == PH_READ) begin
      literal_reg <= instr_reg[LIT_LSB +: DATA_W];                  // see RL3
    end
  end

  assign core_bus.lit = literal_reg;
  assign core_bus.acc = acc_reg;

  // Process: the accumulator is sampled here, so a neighbour write up to the read phase counts.
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      result_reg <= ZERO_BYTE;
      flags_reg  <= STATUS_RESET;
    end else if (phase_reg == PH_PROC) begin
      result_reg <= core_bus.res;                                   // see RL1
      flags_reg  <= core_bus.flags;                                 // see RL2
    end
  end

  // Write: our result wins over a neighbour write in the same cycle, since both cannot retire.
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      acc_reg <= ACC_RESET;
    end else if (write_strobe) begin
      acc_reg <= result_reg;                                        // see RL1
    end else if (i_acc_wr_en) begin
      acc_reg <= i_acc_wr_data;
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      status_reg <= STATUS_RESET;
    end else if (write_strobe) begin
      status_reg <= flags_reg;                                      // see RL2
    end else if (i_status_wr_en) begin
      status_reg <= i_status_wr_data;
    end
  end

  assign o_acc          = acc_reg;
  assign o_status       = status_reg;
  assign o_busy         = (phase_reg != PH_IDLE);
  assign o_write_strobe = write_strobe;

  // Checking helpers: operands as seen in the process phase.
  logic [DATA_W-1:0] chk_lit_q;
  logic [DATA_W-1:0] chk_acc_q;

  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      chk_lit_q <= ZERO_BYTE;
      chk_acc_q <= ACC_RESET;
    end else if (phase_reg == PH_PROC) begin
      chk_lit_q <= literal_reg;
      chk_acc_q <= acc_reg;
    end
  end

  logic signed [DATA_W+1:0] chk_sdiff;
  logic                     chk_ovf;
  logic                     chk_nib;

  always_comb begin
    chk_sdiff = {{2{chk_lit_q[DATA_W-1]}}, chk_lit_q} - {{2{chk_acc_q[DATA_W-1]}}, chk_acc_q};
    chk_ovf   = (chk_sdiff > 10'sh07F) || (chk_sdiff < -10'sh080);
    chk_nib   = (chk_lit_q[NIBBLE_W-1:0] >= chk_acc_q[NIBBLE_W-1:0]);
  end

  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (!i_rst_n);

  logic proc_ours;
  assign proc_ours = (phase_reg == PH_PROC) && hit_reg;

  sequence seq_issue;
    start_ok && decode_hit;
  endsequence

  sequence seq_phases;
    (phase_reg == PH_READ) ##1 (phase_reg == PH_PROC) ##1 (phase_reg == PH_WRITE && write_strobe)
    ##1 (phase_reg == PH_IDLE);
  endsequence

  chk_result_value: assert property ( // see RL1
    proc_ours |=> ##1 (o_acc == DATA_W'(chk_lit_q - chk_acc_q)))
    else $error("accumulator does not hold literal minus accumulator");

  chk_status_only: assert property ( // see RL2
    $changed(o_status) |-> ($past(write_strobe) || $past(i_status_wr_en)))
    else $error("status changed without a write");

  chk_decode_match: assert property ( // see RL3
    start_ok |=> (hit_reg == $past(decode_hit)) ##1 (literal_reg == instr_reg[LIT_LSB +: DATA_W]))
    else $error("decode or literal capture wrong");

  chk_four_phase: assert property ( // see RL4
    seq_issue |=> seq_phases)
    else $error("instruction did not complete in one four-phase cycle");

  chk_borrow_flags: assert property ( // see RL5
    (proc_ours && (acc_reg > literal_reg)) |=> ##1
      (!o_status[FLAG_CARRY] && !o_status[FLAG_ZERO] && (o_status[FLAG_NEG] == o_acc[DATA_W-1])))
    else $error("borrow case flags wrong");

  chk_equal_flags: assert property ( // see RL6
    (proc_ours && (acc_reg == literal_reg)) |=> ##1
      (o_acc == ZERO_BYTE && o_status[FLAG_ZERO] && o_status[FLAG_CARRY] && !o_status[FLAG_NEG]))
    else $error("equal case flags wrong");

  chk_positive_flags: assert property ( // see RL7
    (proc_ours && (literal_reg > acc_reg)) |=> ##1
      (o_status[FLAG_CARRY] && !o_status[FLAG_ZERO] && o_acc != ZERO_BYTE))
    else $error("positive case flags wrong");

  chk_nibble_ovf: assert property ( // see RL8
    proc_ours |=> ##1 (o_status[FLAG_NIBBLE] == chk_nib && o_status[FLAG_OVF] == chk_ovf
      && o_status[FLAG_NEG] == o_acc[DATA_W-1]))
    else $error("nibble carry, overflow or negative flag wrong");

  // A word with another opcode runs the phases but must never retire a result.
  chk_foreign_quiet: assert property ( // see RL3
    (start_ok && !decode_hit) |=> (!write_strobe) [*3])
    else $error("foreign instruction produced a write strobe");

  // A start arriving mid-instruction must leave the latched word and decode untouched.
  chk_busy_start: assert property ( // see RL4
    (i_cycle_start && o_busy) |=> ($stable(hit_reg) && $stable(instr_reg)))
    else $error("start during busy was not ignored");

  // The accumulator only moves on our write strobe or a neighbour write.
  chk_acc_only: assert property ( // see RL1
    $changed(o_acc) |-> ($past(write_strobe) || $past(i_acc_wr_en)))
    else $error("accumulator changed without a write");

endmodule

/* dv/tb.sv */
// Self-checking bench for the subtract-accumulator-from-literal datapath slice.
`timescale 1ns/1ps
module tb;
  import alu_pkg::*;

  typedef struct {
    logic [DATA_W-1:0] acc;
    logic [FLAG_W-1:0] st;
    int                cyc;
  } exp_t;

  logic                i_clk;
  logic                i_rst_n;
  logic                i_cycle_start;
  logic [INSTR_W-1:0]  i_instr;
  logic                i_acc_wr_en;
  logic [DATA_W-1:0]   i_acc_wr_data;
  logic                i_status_wr_en;
  logic [FLAG_W-1:0]   i_status_wr_data;
  logic [DATA_W-1:0]   o_acc;
  logic [FLAG_W-1:0]   o_status;
  logic                o_busy;
  logic                o_write_strobe;
  int                  bad_count;
  int                  compares;
  int                  cyc;
  exp_t                exp_q[$];
  exp_t                got;
  logic [DATA_W-1:0]   acc_model;
  logic [FLAG_W-1:0]   st_model;
  logic [7:0]          tbl_acc [7] = '{8'h01, 8'h02, 8'h03, 8'h01, 8'hFF, 8'h0F, 8'h00};
  logic [7:0]          tbl_lit [7] = '{8'h02, 8'h02, 8'h02, 8'h80, 8'h7F, 8'h10, 8'h00};

  subtract_w_from_literal_alu u_dut (
    .i_clk            (i_clk),
    .i_rst_n          (i_rst_n),
    .i_cycle_start    (i_cycle_start),
    .i_instr          (i_instr),
    .i_acc_wr_en      (i_acc_wr_en),
    .i_acc_wr_data    (i_acc_wr_data),
    .i_status_wr_en   (i_status_wr_en),
    .i_status_wr_data (i_status_wr_data),
    .o_acc            (o_acc),
    .o_status         (o_status),
    .o_busy           (o_busy),
    .o_write_strobe   (o_write_strobe)
  );

  initial i_clk = 1'b0;
  always #50 i_clk = ~i_clk;
  initial cyc = 0;
  always @(posedge i_clk) cyc <= cyc + 1;

  task automatic chk(input string name, input logic [7:0] seen, input logic [7:0] exp);
    compares++;
    if (seen !== exp) begin
      bad_count++;
      $display("MISMATCH %s expected %0h seen %0h", name, exp, seen);
    end
  endtask

  task automatic results();
    $display("checks %0d mismatches %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask

  // The carry flags are "no borrow" style: carry and nibble carry set when nothing was borrowed.
  function automatic logic [FLAG_W-1:0] flags_of(input logic [7:0] k, input logic [7:0] a);
    logic [7:0]        r;
    logic [FLAG_W-1:0] f;
    r = k - a;
    f = 5'h00;
    f[FLAG_CARRY]  = (k >= a);
    f[FLAG_NIBBLE] = (k[3:0] >= a[3:0]);
    f[FLAG_ZERO]   = (r == 8'h00);
    f[FLAG_OVF]    = (k[7] != a[7]) && (r[7] != k[7]);
    f[FLAG_NEG]    = r[7];
    return f;
  endfunction

  task automatic wr_acc(input logic [7:0] d);
    i_acc_wr_en = 1'b1;
    i_acc_wr_data = d;
    @(posedge i_clk); #1;
    i_acc_wr_en = 1'b0;
    acc_model = d;
    chk("acc_write", o_acc, d);
  endtask

  // Mode 0 plain, 1 stray start while busy, 2 operand written in c1, 3 write collides in c3.
  task automatic issue(input logic [15:0] w, input int mode, input logic [7:0] d);
    exp_t e;
    logic match;
    match = (w[15:8] === OPCODE_SUB_LIT);
    if (mode == 2) acc_model = d;
    i_cycle_start = 1'b1;
    i_instr = w;
    if (match) begin
      e.acc = w[7:0] - acc_model;
      e.st = flags_of(w[7:0], acc_model);
      e.cyc = cyc + 3;
      exp_q.push_back(e);
      acc_model = e.acc;
      st_model = e.st;
    end
    @(posedge i_clk); #1;
    i_cycle_start = 1'b0;
    chk("busy_c1", o_busy, 8'h01);
    i_acc_wr_en = (mode == 2);
    i_acc_wr_data = d;
    @(posedge i_clk); #1;
    i_acc_wr_en = 1'b0;
    i_cycle_start = (mode == 1);
    i_instr = 16'h08FF;
    @(posedge i_clk); #1;
    i_cycle_start = 1'b0;
    chk("busy_c3", o_busy, 8'h01);
    i_acc_wr_en = (mode == 3);
    @(posedge i_clk); #1;
    i_acc_wr_en = 1'b0;
    chk("busy_c4", o_busy, 8'h00);
    chk("acc_after", o_acc, acc_model);
    chk("status_after", o_status, st_model);
  endtask

  // A result is due whenever the write strobe shows; the new state is visible one cycle on.
  always @(negedge i_clk) begin
    if (o_write_strobe === 1'b1) begin
      if (exp_q.size() == 0) begin
        chk("unexpected_strobe", 8'h01, 8'h00);
      end else begin
        got = exp_q.pop_front();
        chk("strobe_cycle", cyc[7:0], got.cyc[7:0]);
        @(posedge i_clk); #1;
        chk("result", o_acc, got.acc);
        chk("flags", o_status, got.st);
      end
    end
  end

  initial begin
    #2_000_000;
    bad_count++;
    results();
  end

  initial begin
    logic [15:0] w;
    int mode;
    void'($urandom(32'h92f965a6));
    {i_rst_n, i_cycle_start, i_acc_wr_en, i_status_wr_en} = 4'h0;
    {i_instr, i_acc_wr_data, i_status_wr_data} = 29'h0;
    bad_count = 0;
    compares = 0;
    repeat (5) @(posedge i_clk);
    #1;
    i_rst_n = 1'b1;
    chk("reset_acc", o_acc, ACC_RESET);
    chk("reset_status", o_status, STATUS_RESET);
    chk("reset_busy", o_busy, 8'h00);
    acc_model = ACC_RESET;
    st_model = STATUS_RESET;
    for (int i = 0; i < 7; i++) begin
      wr_acc(tbl_acc[i]);
      issue({OPCODE_SUB_LIT, tbl_lit[i]}, 0, 8'h00);
    end
    i_status_wr_en = 1'b1;
    i_status_wr_data = 5'h15;
    @(posedge i_clk); #1;
    i_status_wr_en = 1'b0;
    st_model = 5'h15;
    chk("status_write", o_status, st_model);
    issue(16'h0902, 0, 8'h00);
    issue(16'h8808, 2, 8'h44);
    issue(16'h0840, 1, 8'h00);
    issue(16'h0811, 2, 8'h33);
    issue(16'h0822, 3, 8'h5A);
    for (int i = 0; i < 40; i++) begin
      mode = $urandom_range(0, 3);
      w = {($urandom_range(0, 7) == 0) ? 8'($urandom) : OPCODE_SUB_LIT, 8'($urandom)};
      if (mode == 3 && w[15:8] !== OPCODE_SUB_LIT) mode = 0;
      if ($urandom_range(0, 3) == 0) wr_acc(8'($urandom));
      issue(w, mode, 8'($urandom));
    end
    repeat (3) @(posedge i_clk);
    chk("pending", 8'(exp_q.size()), 8'h00);
    results();
  end
endmodule
